// ### rtl/lpb_pkg.sv
// shared constants for the led pwm bank and fault supervisor
`default_nettype none
package lpb_pkg;
  localparam int          CHANNELS        = 36;
  localparam int          MODULES         = 12;
  localparam int          BANKS           = 3;
  localparam int          COLOUR_W        = 8;
  localparam int          PWM_W           = 9;
  localparam logic [9:0]  PWM_PERIOD      = 10'h200;
  localparam logic [9:0]  PWM_CENTRE      = 10'h100;
  localparam int          PRODUCT_W       = 16;
  localparam int          DUTY_LSB        = 7;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          WARN_PERSIST_NS = 33000;
  localparam int          WARN_CYCLES     = (WARN_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PSAVE_MS        = 30;
  localparam int          PSAVE_CYCLES    = (PSAVE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PERSIST_W       = 13;
  localparam int          PSAVE_W         = 22;
  localparam logic [5:0]  FAULT_WAIT_UNIT = 6'h08;
  localparam logic [2:0]  GROUP_HIGH_BITS = 3'h4;
  localparam logic        POR_FLAG_RESET  = 1'b1;
  localparam logic [35:0] FLAGS_RESET     = 36'h0;

  typedef enum logic [1:0] {
    LPB_INIT   = 2'b10,
    LPB_NORMAL = 2'b00,
    LPB_PSAVE  = 2'b01
  } lpb_mode_t;
endpackage : lpb_pkg
`default_nettype wire

// ### rtl/lpb_persist.sv
// synchroniser plus persistence counter for one comparator input
`default_nettype none
module lpb_persist
  import lpb_pkg::*;
#(
  parameter int CW = PERSIST_W
)
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire logic          cond_async,
  input  wire logic [CW-1:0] limit,
  output logic               held
);
  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] cnt_reg;
  logic          held_reg;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else if (ce)
    begin
      sync1_reg <= cond_async;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_reg  <= '0;
      held_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (!sync2_reg)
        cnt_reg <= '0;
      else if (cnt_reg < limit)
        cnt_reg <= cnt_reg + 1'b1;
      held_reg <= sync2_reg && (cnt_reg >= limit);
    end
  end

  assign held = held_reg;
endmodule : lpb_persist
`default_nettype wire

// ### rtl/lpb_top.sv
// led pwm output stage with bank select, power save and fault supervision
// How it works
// - phase-one channels: rising edge fixed at period start, falling edge moves
// - phase-two channels: pulse centred mid-period, widens both ways
// - phase-three channels: falling edge fixed at period end, rising edge moves
// - per-module group select chooses own values (0) or bank values (1)
// - bank mode duty from bank colour and bank brightness, same product path
// - channel n uses bank n mod 3 and module n div 3
// - group select: low byte modules 0-7, high low nibble modules 8-11
// - all values zero over 30ms with save enabled enters power save
// - any bus command wakes from power save, values kept
// - open comparator held past persistence time latches channel and global open
// - persistence selector picks 8, 16, 24 or 32 clocks
// - short comparator held past persistence time latches channel and global short
// - hot warning held over 33us latches flag, released below lower threshold
// - shutdown comparator disables outputs until release comparator shows cooling
// - low supply warning held over 33us latches flag, released above upper threshold
// - lockout holds internal reset, init mode and fault pin low
// - power-on flag set on every reset; host clears it early
// - per-channel and global open blocks keep open faults off fault pin
// - per-channel and global short blocks keep short faults off fault pin
// - separate blocks for hot warning, low supply warning and power-on
// - fault pin low while any unmasked fault active or latched
// - period is 512 clocks, edges on that grid
`default_nettype none
module lpb_top
  import lpb_pkg::*;
#(
  parameter int WARN_PERSIST_CYCLES = WARN_CYCLES,
  parameter int PSAVE_WAIT_CYCLES   = PSAVE_CYCLES
)
(
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          ce,
  input  wire logic [CHANNELS*COLOUR_W-1:0]  channel_colour,
  input  wire logic [MODULES*COLOUR_W-1:0]   module_intensity,
  input  wire logic [BANKS*COLOUR_W-1:0]     bank_colour,
  input  wire logic [COLOUR_W-1:0]           bank_intensity,
  input  wire logic [7:0]                    group_select_low,
  input  wire logic [7:0]                    group_select_high,
  input  wire logic                          power_save_enable,
  input  wire logic                          bus_command_seen,
  input  wire logic                          persist_select_high,
  input  wire logic                          persist_select_low,
  input  wire logic [CHANNELS-1:0]           open_cmp_async,
  input  wire logic [CHANNELS-1:0]           short_cmp_async,
  input  wire logic                          hot_warn_cmp_async,
  input  wire logic                          hot_release_cmp_async,
  input  wire logic                          shutdown_cmp_async,
  input  wire logic                          cooled_cmp_async,
  input  wire logic                          low_supply_cmp_async,
  input  wire logic                          supply_ok_cmp_async,
  input  wire logic                          supply_low_lockout_async,
  input  wire logic                          clear_error_command,
  input  wire logic                          power_on_status_clear,
  input  wire logic [CHANNELS-1:0]           channel_open_block,
  input  wire logic                          open_block_all,
  input  wire logic [CHANNELS-1:0]           channel_short_block,
  input  wire logic                          short_block_all,
  input  wire logic                          hot_warning_block,
  input  wire logic                          low_supply_warning_block,
  input  wire logic                          power_on_block,
  output logic [CHANNELS-1:0]                pwm_out,
  output logic [CHANNELS-1:0]                channel_open_flag,
  output logic [CHANNELS-1:0]                channel_short_flag,
  output logic                               open_flag,
  output logic                               short_flag,
  output logic                               hot_warning_status,
  output logic                               low_supply_warning_status,
  output logic                               power_on_status,
  output logic                               thermal_shutdown_active,
  output logic                               power_save_active,
  output logic                               internal_reset_active,
  output logic                               fault_n_out,
  output logic                               fault_n_oe
);
  logic [9:0]                    pwm_cnt_reg;
  logic [PWM_W-1:0]              duty_reg [CHANNELS];
  logic [CHANNELS-1:0]           pwm_reg;
  logic [CHANNELS-1:0]           open_held;
  logic [CHANNELS-1:0]           short_held;
  logic [CHANNELS-1:0]           open_flag_reg;
  logic [CHANNELS-1:0]           short_flag_reg;
  logic                          open_any_reg;
  logic                          short_any_reg;
  logic [5:0]                    mon_async;
  logic [5:0]                    mon_held;
  logic                          hot_held, low_held, hot_rel, low_rel, tsd_in, cooled;
  logic                          lockout;
  logic                          hot_active_reg;
  logic                          low_active_reg;
  logic                          hot_flag_reg;
  logic                          low_flag_reg;
  logic                          por_reg;
  logic                          tsd_reg;
  logic                          fault_reg;
  logic [PSAVE_W-1:0]            zero_cnt_reg;
  lpb_mode_t                     mode_reg;
  logic                          rst_int;
  logic [MODULES-1:0]            group_sel;
  logic [PERSIST_W-1:0]          fault_wait;
  logic [PERSIST_W-1:0]          warn_limit;
  logic                          all_zero;
  logic                          outputs_on;
  logic                          fault_any;

  // lockout acts as a chip-wide reset for everything behind it
  assign rst_int = srst || lockout;
  assign group_sel = {group_select_high[GROUP_HIGH_BITS-1:0], group_select_low};
  assign fault_wait = PERSIST_W'(({4'h0, persist_select_high, persist_select_low} + 6'h01) * FAULT_WAIT_UNIT);
  assign warn_limit = PERSIST_W'(WARN_PERSIST_CYCLES);
  assign all_zero = (channel_colour == '0) && (module_intensity == '0)
                    && (bank_colour == '0) && (bank_intensity == '0);
  assign outputs_on = (mode_reg == LPB_NORMAL) && !tsd_reg;
  lpb_persist #(.CW(PERSIST_W)) u_lockout (
    .clk        (clk),
    .srst       (srst),
    .ce         (ce),
    .cond_async (supply_low_lockout_async),
    .limit      ('0),
    .held       (lockout)
  );
  assign mon_async = {cooled_cmp_async, shutdown_cmp_async, supply_ok_cmp_async,
                      hot_release_cmp_async, low_supply_cmp_async, hot_warn_cmp_async};
  assign {cooled, tsd_in, low_rel, hot_rel, low_held, hot_held} = mon_held;
  // two warnings persist; releases, shutdown and cooling act at once
  generate
    for (genvar m = 0; m < 6; m++)
    begin : g_mon
      lpb_persist #(.CW(PERSIST_W)) u_mon (
        .clk        (clk),
        .srst       (rst_int),
        .ce         (ce),
        .cond_async (mon_async[m]),
        .limit      ((m < 2) ? warn_limit : PERSIST_W'(0)),
        .held       (mon_held[m])
      );
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst_int)
      pwm_cnt_reg <= '0;
    else if (ce)
    begin
      if (pwm_cnt_reg == PWM_PERIOD - 10'h001)
        pwm_cnt_reg <= '0;
      else
        pwm_cnt_reg <= pwm_cnt_reg + 10'h001;
    end
  end
  generate
    for (genvar i = 0; i < CHANNELS; i++)
    begin : g_ch
      localparam int PHASE = i % BANKS;
      localparam int MODN  = i / BANKS;
      logic [COLOUR_W-1:0]  col;
      logic [COLOUR_W-1:0]  bri;
      logic [PRODUCT_W-1:0] prod;
      logic [9:0]           width;
      logic [9:0]           start;
      logic                 on;
      assign col   = group_sel[MODN] ? bank_colour[PHASE*COLOUR_W +: COLOUR_W]
                                     : channel_colour[i*COLOUR_W +: COLOUR_W];
      assign bri   = group_sel[MODN] ? bank_intensity
                                     : module_intensity[MODN*COLOUR_W +: COLOUR_W];
      assign prod  = col * bri;
      assign width = {1'b0, duty_reg[i]};
      assign start = (PHASE == 0) ? 10'h000
                   : (PHASE == 1) ? PWM_CENTRE - {1'b0, width[9:1]}
                   : PWM_PERIOD - width;
      assign on = (pwm_cnt_reg >= start) && (pwm_cnt_reg < start + width);
      // duty taken only at period start so edges never tear
      always_ff @(posedge clk)
      begin
        if (rst_int)
          duty_reg[i] <= '0;
        else if (ce && pwm_cnt_reg == '0)
          duty_reg[i] <= prod[DUTY_LSB +: PWM_W];
      end
      always_ff @(posedge clk)
      begin
        if (rst_int)
          pwm_reg[i] <= 1'b0;
        else if (ce)
          pwm_reg[i] <= on && outputs_on;
      end
      lpb_persist #(.CW(PERSIST_W)) u_open (
        .clk        (clk),
        .srst       (rst_int),
        .ce         (ce),
        .cond_async (open_cmp_async[i]),
        .limit      (fault_wait),
        .held       (open_held[i])
      );
      lpb_persist #(.CW(PERSIST_W)) u_short (
        .clk        (clk),
        .srst       (rst_int),
        .ce         (ce),
        .cond_async (short_cmp_async[i]),
        .limit      (fault_wait),
        .held       (short_held[i])
      );
      // set wins over clear
      always_ff @(posedge clk)
      begin
        if (rst_int)
        begin
          open_flag_reg[i]  <= 1'b0;
          short_flag_reg[i] <= 1'b0;
        end
        else if (ce)
        begin
          if (open_held[i])
            open_flag_reg[i] <= 1'b1;
          else if (clear_error_command)
            open_flag_reg[i] <= 1'b0;
          if (short_held[i])
            short_flag_reg[i] <= 1'b1;
          else if (clear_error_command)
            short_flag_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk)
  begin
    if (rst_int)
    begin
      open_any_reg  <= 1'b0;
      short_any_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (|open_held)
        open_any_reg <= 1'b1;
      else if (clear_error_command)
        open_any_reg <= 1'b0;
      if (|short_held)
        short_any_reg <= 1'b1;
      else if (clear_error_command)
        short_any_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst_int)
    begin
      hot_active_reg <= 1'b0;
      low_active_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (hot_held)
        hot_active_reg <= 1'b1;
      else if (hot_rel)
        hot_active_reg <= 1'b0;
      if (low_held)
        low_active_reg <= 1'b1;
      else if (low_rel)
        low_active_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst_int)
    begin
      hot_flag_reg <= 1'b0;
      low_flag_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (hot_held)
        hot_flag_reg <= 1'b1;
      else if (clear_error_command)
        hot_flag_reg <= 1'b0;
      if (low_held)
        low_flag_reg <= 1'b1;
      else if (clear_error_command)
        low_flag_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst_int)
      por_reg <= POR_FLAG_RESET;
    else if (ce && power_on_status_clear)
      por_reg <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (rst_int)
      tsd_reg <= 1'b0;
    else if (ce)
    begin
      if (tsd_in)
        tsd_reg <= 1'b1;
      else if (cooled)
        tsd_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst_int)
      zero_cnt_reg <= '0;
    else if (ce)
    begin
      if (!all_zero || !power_save_enable || mode_reg != LPB_NORMAL)
        zero_cnt_reg <= '0;
      else if (zero_cnt_reg < PSAVE_W'(PSAVE_WAIT_CYCLES))
        zero_cnt_reg <= zero_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst_int)
      mode_reg <= LPB_INIT;
    else if (ce)
    begin
      case (mode_reg)
        LPB_INIT:
          mode_reg <= LPB_NORMAL;
        LPB_NORMAL:
          if (all_zero && power_save_enable && !bus_command_seen
              && zero_cnt_reg >= PSAVE_W'(PSAVE_WAIT_CYCLES))
            mode_reg <= LPB_PSAVE;
        LPB_PSAVE:
          if (bus_command_seen)
            mode_reg <= LPB_NORMAL;
        default:
          mode_reg <= LPB_INIT;
      endcase
    end
  end
  assign fault_any = (|(open_flag_reg & ~channel_open_block) && !open_block_all)
                   || (|(short_flag_reg & ~channel_short_block) && !short_block_all)
                   || ((hot_flag_reg || hot_active_reg) && !hot_warning_block)
                   || ((low_flag_reg || low_active_reg) && !low_supply_warning_block)
                   || (por_reg && !power_on_block)
                   || tsd_reg;
  // lockout pulls the pin low even while held in reset
  always_ff @(posedge clk)
  begin
    if (srst)
      fault_reg <= 1'b0;
    else if (ce)
      fault_reg <= lockout || (!rst_int && fault_any);
  end
  assign pwm_out                   = pwm_reg;
  assign channel_open_flag         = open_flag_reg;
  assign channel_short_flag        = short_flag_reg;
  assign open_flag                 = open_any_reg;
  assign short_flag                = short_any_reg;
  assign hot_warning_status        = hot_flag_reg;
  assign low_supply_warning_status = low_flag_reg;
  assign power_on_status           = por_reg;
  assign thermal_shutdown_active   = tsd_reg;
  assign power_save_active         = (mode_reg == LPB_PSAVE);
  assign internal_reset_active     = lockout;
  assign fault_n_out               = 1'b0;
  assign fault_n_oe                = fault_reg;
endmodule : lpb_top
`default_nettype wire

// ### tb/lpb_checker.sv
// port assertions for the led pwm bank and fault supervisor
`default_nettype none
module lpb_checker
  import lpb_pkg::*;
#(
  parameter int WARN_PERSIST_CYCLES = WARN_CYCLES,
  parameter int PSAVE_WAIT_CYCLES   = PSAVE_CYCLES
)
(
  input wire logic                clk,
  input wire logic                srst,
  input wire logic                ce,
  input wire logic                bus_command_seen,
  input wire logic                clear_error_command,
  input wire logic                power_on_status_clear,
  input wire logic                hot_warning_block,
  input wire logic                power_on_block,
  input wire logic [CHANNELS-1:0] pwm_out,
  input wire logic [CHANNELS-1:0] channel_open_flag,
  input wire logic [CHANNELS-1:0] channel_short_flag,
  input wire logic                open_flag,
  input wire logic                short_flag,
  input wire logic                hot_warning_status,
  input wire logic                power_on_status,
  input wire logic                thermal_shutdown_active,
  input wire logic                power_save_active,
  input wire logic                internal_reset_active,
  input wire logic                fault_n_out,
  input wire logic                fault_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wake;
    ce && power_save_active && bus_command_seen;
  endsequence
  sequence s_dark;
    pwm_out == '0;
  endsequence
  a_open_global: assert property (open_flag == (|channel_open_flag)) else $error("open summary wrong");
  a_short_global: assert property (short_flag == (|channel_short_flag)) else $error("short summary wrong");
  a_flag_hold: assert property ($fell(open_flag) |->
    $past(clear_error_command) || $past(internal_reset_active)) else $error("open flag lost");
  a_por_hold: assert property ($fell(power_on_status) |-> $past(power_on_status_clear))
    else $error("power-on flag lost");
  a_save_wake: assert property (s_wake |=> !power_save_active) else $error("no wake");
  a_save_dark: assert property (power_save_active [*2] |-> s_dark) else $error("pwm in save");
  a_tsd_dark: assert property (thermal_shutdown_active [*2] |-> s_dark) else $error("pwm hot");
  a_tsd_pin: assert property (thermal_shutdown_active |=> fault_n_oe) else $error("no pin");
  a_hot_pin: assert property (hot_warning_status && !hot_warning_block |=> fault_n_oe)
    else $error("hot pin missing");
  a_por_pin: assert property (power_on_status && !power_on_block |=> fault_n_oe)
    else $error("power-on pin missing");
  a_lock_pin: assert property (internal_reset_active |=> fault_n_oe) else $error("lock pin");
  a_pin_low: assert property (fault_n_out == 1'b0) else $error("pin level wrong");
endmodule : lpb_checker
bind lpb_top lpb_checker #(.WARN_PERSIST_CYCLES(WARN_PERSIST_CYCLES), .PSAVE_WAIT_CYCLES(PSAVE_WAIT_CYCLES))
  lpb_checker_i (.clk, .srst, .ce, .bus_command_seen, .clear_error_command, .power_on_status_clear,
  .hot_warning_block, .power_on_block, .pwm_out, .channel_open_flag, .channel_short_flag, .open_flag,
  .short_flag, .hot_warning_status, .power_on_status, .thermal_shutdown_active, .power_save_active,
  .internal_reset_active, .fault_n_out, .fault_n_oe);
`default_nettype wire

// ### tb/lpb_host.sv
// host controller model: flag clears and shorted channel shut-off
`default_nettype none
module lpb_host
  import lpb_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [CHANNELS-1:0] channel_short_flag,
  output logic                     clear_error_command,
  output logic                     power_on_status_clear,
  output logic [CHANNELS-1:0]      chan_off
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    clear_error_command = 1'h0;
    power_on_status_clear = 1'h0;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      chan_off <= '0;
    else
      chan_off <= chan_off | channel_short_flag;
  end
  task automatic pulse(input bit por);
    @(posedge clk);
    if (por)
      power_on_status_clear <= 1'h1;
    else
      clear_error_command <= 1'h1;
    @(posedge clk);
    power_on_status_clear <= 1'h0;
    clear_error_command <= 1'h0;
  endtask : pulse
endmodule : lpb_host
`default_nettype wire

// ### tb/lpb_top_tb_top.sv
// self-checking bench for the led pwm bank and fault supervisor
`default_nettype none
module lpb_top_tb_top
  import lpb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WARN = 20;
  logic clk = 1'h0, srst = 1'h1, ce = 1'h1;
  logic [CHANNELS*COLOUR_W-1:0] colour = '0;
  logic [MODULES*COLOUR_W-1:0] module_intensity = '0;
  logic [23:0] bank_colour = '0;
  logic [7:0] bank_intensity = '0, group_select_low = '0, group_select_high = '0;
  logic power_save_enable = 1'h0, bus_command_seen = 1'h0, persist_select_high = 1'h0, persist_select_low = 1'h0;
  logic [35:0] open_cmp_async = '0, short_cmp_async = '0, channel_open_block = '0, channel_short_block = '0;
  logic [1:0] warn_cmp = '0, rel_cmp = 2'h3, warn_blk = '0;
  logic shutdown_cmp_async = 1'h0, cooled_cmp_async = 1'h1, supply_low_lockout_async = 1'h0;
  logic open_block_all = 1'h0, short_block_all = 1'h0, power_on_block = 1'h0;
  wire logic [35:0] pwm_out, channel_open_flag, channel_short_flag, chan_off;
  wire logic [CHANNELS*COLOUR_W-1:0] channel_colour;
  wire logic open_flag, short_flag, hot_warning_status, low_supply_warning_status, power_on_status;
  wire logic thermal_shutdown_active, power_save_active, internal_reset_active, fault_n_oe;
  wire logic clear_error_command, power_on_status_clear;
  wire logic [1:0] warn_flag = {low_supply_warning_status, hot_warning_status};
  int n_fail = 0, n_checks = 0, cyc = 0, n;
  int hi [36], rise [36];
  int bw [3] = '{128, 64, 16};

  for (genvar g = 0; g < CHANNELS; g++)
  begin : g_off
    assign channel_colour[g*COLOUR_W +: COLOUR_W] = chan_off[g] ? 8'h00 : colour[g*COLOUR_W +: COLOUR_W];
  end

  lpb_top #(.WARN_PERSIST_CYCLES(WARN), .PSAVE_WAIT_CYCLES(50)) lpb_top_i (
    .clk, .srst, .ce, .channel_colour, .module_intensity, .bank_colour, .bank_intensity,
    .group_select_low, .group_select_high, .power_save_enable, .bus_command_seen,
    .persist_select_high, .persist_select_low, .open_cmp_async, .short_cmp_async,
    .hot_warn_cmp_async(warn_cmp[0]), .hot_release_cmp_async(rel_cmp[0]), .shutdown_cmp_async,
    .cooled_cmp_async, .low_supply_cmp_async(warn_cmp[1]), .supply_ok_cmp_async(rel_cmp[1]),
    .supply_low_lockout_async, .clear_error_command, .power_on_status_clear, .channel_open_block,
    .open_block_all, .channel_short_block, .short_block_all, .hot_warning_block(warn_blk[0]),
    .low_supply_warning_block(warn_blk[1]), .power_on_block, .pwm_out, .channel_open_flag,
    .channel_short_flag, .open_flag, .short_flag, .hot_warning_status, .low_supply_warning_status,
    .power_on_status, .thermal_shutdown_active, .power_save_active, .internal_reset_active,
    .fault_n_out(), .fault_n_oe);
  lpb_host lpb_host_i (.clk, .srst, .channel_short_flag, .clear_error_command, .power_on_status_clear, .chan_off);

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic results;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task flip(input bit sh, input int ch);
    if (sh)
      short_cmp_async[ch] <= ~short_cmp_async[ch];
    else
      open_cmp_async[ch] <= ~open_cmp_async[ch];
  endtask : flip

  // glitch shorter than the wait, then a held condition
  task automatic fault_run(input int ch, input bit sh, input logic [1:0] code, input bit blk);
    @(posedge clk);
    {persist_select_high, persist_select_low} <= code;
    flip(sh, ch);
    repeat (6) @(posedge clk);
    flip(sh, ch);
    @(posedge clk);
    flip(sh, ch);
    n = 0;
    while ((sh ? channel_short_flag[ch] : channel_open_flag[ch]) !== 1'h1 && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, 8 * code + 12);
    check(sh ? short_flag : open_flag, 1);
    tick(1);
    check(fault_n_oe, !blk);
    @(posedge clk);
    flip(sh, ch);
    tick(4);
    check(sh ? channel_short_flag[ch] : channel_open_flag[ch], 1);
    lpb_host_i.pulse(1'h0);
    #1;
    check(sh ? channel_short_flag[ch] : channel_open_flag[ch], 0);
    tick(1);
    check(fault_n_oe, 0);
  endtask : fault_run

  task automatic warn_run(input bit sel, input bit blk);
    @(posedge clk);
    warn_blk <= {2{blk}} & (2'h1 << sel);
    warn_cmp <= 2'h1 << sel;
    rel_cmp <= ~(2'h1 << sel);
    n = 0;
    while (warn_flag[sel] !== 1'h1 && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, WARN + 4);
    tick(1);
    check(fault_n_oe, !blk);
    @(posedge clk);
    warn_cmp <= '0;
    tick(4);
    lpb_host_i.pulse(1'h0);
    tick(2);
    check(fault_n_oe, !blk);
    @(posedge clk);
    rel_cmp <= 2'h3;
    tick(4);
    lpb_host_i.pulse(1'h0);
    #1;
    check(warn_flag[sel], 0);
    tick(1);
    check(fault_n_oe, 0);
  endtask : warn_run

  task automatic measure;
    logic [35:0] prev;
    prev = pwm_out;
    hi = '{default: 0};
    rise = '{default: 0};
    for (int k = 0; k < 512; k++)
    begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 36; i++)
      begin
        hi[i] += int'(pwm_out[i]);
        if (pwm_out[i] && !prev[i])
          rise[i] = k;
      end
      prev = pwm_out;
    end
  endtask : measure

  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    tick(2);
    check(power_on_status, 1);
    check(fault_n_oe, 1);
    check({open_flag, short_flag, channel_open_flag}, 0);
    @(posedge clk);
    power_on_block <= 1'h1;
    tick(2);
    check(fault_n_oe, 0);
    @(posedge clk);
    power_on_block <= 1'h0;
    lpb_host_i.pulse(1'h1);
    tick(2);
    check({power_on_status, fault_n_oe}, 0);
    for (int c = 0; c < 4; c++)
    begin
      fault_run(9 + c, 1'h0, 2'(c), 1'h0);
      fault_run(14 + c, 1'h1, 2'(c), 1'h0);
    end
    @(posedge clk);
    channel_open_block <= 36'h000100000;
    channel_short_block <= 36'h000200000;
    fault_run(20, 1'h0, 2'h0, 1'h1);
    fault_run(21, 1'h1, 2'h0, 1'h1);
    fault_run(22, 1'h0, 2'h0, 1'h0);
    @(posedge clk);
    open_block_all <= 1'h1;
    short_block_all <= 1'h1;
    fault_run(23, 1'h0, 2'h0, 1'h1);
    fault_run(24, 1'h1, 2'h0, 1'h1);
    for (int b = 0; b < 4; b++)
      warn_run(b[0], b[1]);
    @(posedge clk);
    colour <= {36{8'h40}};
    module_intensity <= {12{8'h40}};
    bank_colour <= {8'h10, 8'h40, 8'h80};
    bank_intensity <= 8'h80;
    group_select_low <= 8'hFE;
    group_select_high <= 8'h0F;
    tick(1100);
    measure();
    for (int i = 0; i < 3; i++)
    begin
      check(hi[i], 32);
      check(hi[3 + i], bw[i]);
      check(hi[33 + i], bw[i]);
    end
    check((rise[6] - rise[0]) & 511, 0);
    check((rise[1] - rise[0]) & 511, 240);
    check((rise[7] - rise[0]) & 511, 224);
    check((rise[2] - rise[0]) & 511, 480);
    check((rise[8] - rise[0]) & 511, 496);
    @(posedge clk);
    shutdown_cmp_async <= 1'h1;
    cooled_cmp_async <= 1'h0;
    tick(8);
    check({thermal_shutdown_active, fault_n_oe, pwm_out}, {2'h3, 36'h0});
    @(posedge clk);
    shutdown_cmp_async <= 1'h0;
    tick(8);
    check(thermal_shutdown_active, 1);
    @(posedge clk);
    cooled_cmp_async <= 1'h1;
    tick(8);
    check(thermal_shutdown_active, 0);
    tick(600);
    measure();
    check(hi[0], 32);
    @(posedge clk);
    colour <= '0;
    module_intensity <= '0;
    bank_colour <= '0;
    bank_intensity <= '0;
    tick(200);
    check(power_save_active, 0);
    @(posedge clk);
    power_save_enable <= 1'h1;
    tick(100);
    check(power_save_active, 1);
    @(posedge clk);
    bus_command_seen <= 1'h1;
    @(posedge clk);
    bus_command_seen <= 1'h0;
    #1;
    check(power_save_active, 0);
    @(posedge clk);
    supply_low_lockout_async <= 1'h1;
    tick(5);
    check({internal_reset_active, fault_n_oe, power_on_status}, 3'h7);
    @(posedge clk);
    supply_low_lockout_async <= 1'h0;
    tick(6);
    check(internal_reset_active, 0);
    results();
  end
endmodule : lpb_top_tb_top
`default_nettype wire
